//--- hw/nvmem_host_pkg.sv
package nvmem_host_pkg;

  // ****************************************
  // widths of the memory port and the counters
  // ****************************************
  localparam int ADDR_W = 13;  // 8K byte locations
  localparam int DATA_W = 8;   // byte lines
  localparam int CNT_W = 8;    // phase and cycle counters
  localparam int PWR_W = 24;   // power-up wait counter

  // ****************************************
  // clock and timing figures
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;  // 250 MHz system clock

  // lower supply range (2.7 V to 3.0 V), figures in ns
  localparam int SELECT_LOW_MIN_LO_NS = 80;
  localparam int READ_CYCLE_MIN_LO_NS = 145;
  localparam int PRECHARGE_MIN_LO_NS = 65;
  localparam int STROBE_WIDTH_MIN_LO_NS = 50;
  localparam int DATA_SETUP_MIN_LO_NS = 40;
  // upper supply range (3.0 V to 5.5 V), figures in ns
  localparam int SELECT_LOW_MIN_HI_NS = 70;
  localparam int READ_CYCLE_MIN_HI_NS = 130;
  localparam int PRECHARGE_MIN_HI_NS = 60;
  localparam int STROBE_WIDTH_MIN_HI_NS = 40;
  localparam int DATA_SETUP_MIN_HI_NS = 30;
  // power-up wait before the first access, in ms
  localparam int POWERUP_WAIT_MIN_MS = 10;

  // least times round up to whole cycles
  localparam int SELECT_LOW_LO_CYC = (SELECT_LOW_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_LOW_HI_CYC = (SELECT_LOW_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_LO_CYC = (READ_CYCLE_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_HI_CYC = (READ_CYCLE_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_LO_CYC = (PRECHARGE_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_HI_CYC = (PRECHARGE_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LO_CYC = (STROBE_WIDTH_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HI_CYC = (STROBE_WIDTH_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_LO_CYC = (DATA_SETUP_MIN_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_HI_CYC = (DATA_SETUP_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_CYC = (POWERUP_WAIT_MIN_MS * 1000000) / CLK_PERIOD_NS;
  // extra select-low cycles on a read to cover the two-flop data synchroniser
  localparam int READ_SYNC_CYC = 3;

  // ****************************************
  // controller states, one-hot
  // ****************************************
  typedef enum logic [6:0] {
    ST_POWERUP   = 7'h01,
    ST_IDLE      = 7'h02,
    ST_SETUP     = 7'h04,
    ST_ACTIVE    = 7'h08,
    ST_END       = 7'h10,
    ST_PRECHARGE = 7'h20,
    ST_SPARE     = 7'h40
  } state_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic write;                 // 1 write, 0 read
    logic select_ctl;            // write style: 1 select controlled, 0 strobe controlled
    logic low_supply;            // 1 lower supply range timing
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;

  typedef struct packed {
    logic ce_n;                  // chip select, active low
    logic we_n;                  // write strobe, active low
    logic oe_n;                  // output drive enable, active low
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;       // byte lines, host drive value
    logic dq_oe;                 // high while host drives byte lines
  } mem_pins_s;

endpackage

//--- hw/nvmem_host.sv
// Notes on behaviour
// RULE1: memory latches address on select falling edge
// RULE2: two write styles chosen by strobe order
// RULE3: output enable gates only the data drivers
// RULE4: read data valid by access time
// RULE5: select held low its least time
// RULE6: data appears shortly after output enable
// RULE7: byte lines float after select or enable rise
// RULE8: strobe held low its least width
// RULE9: write data set up before write end
// RULE10: select low long enough before strobe rises
// RULE11: memory floats byte lines during write strobe
// RULE12: wait after power-up before first access
// RULE13: power may drop right after last write
// RULE14: whole cycle and precharge least lengths
// RULE15: address stable from select fall, held after
`timescale 1ns/10ps
module nvmem_host #(
  parameter int POWERUP_CYC = nvmem_host_pkg::POWERUP_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic req_valid_i,
  input wire nvmem_host_pkg::req_s req_i,
  output nvmem_host_pkg::mem_pins_s mem_o,
  input wire logic [nvmem_host_pkg::DATA_W-1:0] mem_dq_i,
  output logic ready_o,
  output logic rvalid_o,
  output logic [nvmem_host_pkg::DATA_W-1:0] rdata_o,
  output logic done_o
);

  // ****************************************
  // timing selection
  // ****************************************
  // pick one of two cycle counts by supply range
  function automatic logic [nvmem_host_pkg::CNT_W-1:0] pick(input logic lo, input int a,
                                                            input int b);
    pick = lo ? nvmem_host_pkg::CNT_W'(a) : nvmem_host_pkg::CNT_W'(b);
  endfunction

  nvmem_host_pkg::state_e state_r, state_nxt;  // controller state
  nvmem_host_pkg::req_s req_r, req_nxt;        // request held for the whole cycle
  nvmem_host_pkg::mem_pins_s mem_r, mem_nxt;   // pin drive
  logic [nvmem_host_pkg::CNT_W-1:0] cnt_r, cnt_nxt;  // cycles in current phase
  logic [nvmem_host_pkg::CNT_W-1:0] cyc_r, cyc_nxt;  // cycles since select fell
  logic ready_r, ready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic done_r, done_nxt;
  logic [nvmem_host_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic [nvmem_host_pkg::PWR_W-1:0] pwr_r, pwr_nxt;  // power-up wait counter
  logic pwr_ok_r, pwr_ok_nxt;
  logic [nvmem_host_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;  // byte line synchroniser
  logic [nvmem_host_pkg::CNT_W-1:0] sel_low, cyc_min, pc_min, act_len;

  // counts for the latched supply range
  assign sel_low = pick(req_r.low_supply, nvmem_host_pkg::SELECT_LOW_LO_CYC,
                        nvmem_host_pkg::SELECT_LOW_HI_CYC);
  // precharge and cycle always use the longer range: the range of the next request is
  // not known yet, and a short precharge would break a lower-range access that follows
  assign cyc_min = nvmem_host_pkg::CNT_W'(nvmem_host_pkg::CYCLE_LO_CYC);
  assign pc_min = nvmem_host_pkg::CNT_W'(nvmem_host_pkg::PRECHARGE_LO_CYC);
  // reads stay selected longer so the synchronised byte is settled
  assign act_len = req_r.write ? sel_low
                 : sel_low + nvmem_host_pkg::CNT_W'(nvmem_host_pkg::READ_SYNC_CYC);

  // ****************************************
  // byte line synchroniser
  // ****************************************
  // the pins are asynchronous to sys_clk_i; only the second stage is read
  always_ff @(posedge sys_clk_i) begin
    dq_s1_r <= mem_dq_i;
    dq_s2_r <= dq_s1_r;
  end

  // ****************************************
  // power-up wait
  // ****************************************
  // counts from reset release; no access until it ends
  always_comb begin
    pwr_nxt = pwr_r;
    pwr_ok_nxt = pwr_ok_r;
    if (!pwr_ok_r) begin
      if (pwr_r >= nvmem_host_pkg::PWR_W'(POWERUP_CYC - 1)) begin
        pwr_ok_nxt = 1'b1;
      end else begin
        pwr_nxt = pwr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      pwr_r <= '0;
      pwr_ok_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      pwr_ok_r <= pwr_ok_nxt;
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  // one access at a time; address and write data stay put the whole cycle
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    mem_nxt = mem_r;
    cnt_nxt = cnt_r + 1'b1;
    cyc_nxt = cyc_r + 1'b1;
    ready_nxt = 1'b0;
    rvalid_nxt = 1'b0;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    case (state_r)
      // RULE12: hold off accesses
      nvmem_host_pkg::ST_POWERUP: begin
        if (pwr_ok_r) begin
          state_nxt = nvmem_host_pkg::ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
      nvmem_host_pkg::ST_IDLE: begin
        ready_nxt = 1'b1;
        if (req_valid_i && ready_r) begin
          ready_nxt = 1'b0;
          req_nxt = req_i;
          // RULE15: address set on the edge select falls, one cycle earlier on select-controlled writes
          mem_nxt.addr = req_i.addr;
          mem_nxt.dq = req_i.wdata;
          mem_nxt.dq_oe = req_i.write;
          cnt_nxt = '0;
          cyc_nxt = '0;
          if (req_i.write && req_i.select_ctl) begin
            // RULE2: strobe low first, select falls next
            mem_nxt.we_n = 1'b0;
            state_nxt = nvmem_host_pkg::ST_SETUP;
          end else begin
            // RULE3: enable only on reads; writes keep device drivers off
            mem_nxt.ce_n = 1'b0;
            mem_nxt.oe_n = req_i.write;
            state_nxt = nvmem_host_pkg::ST_ACTIVE;
          end
        end
      end
      // select-controlled write: strobe already low
      nvmem_host_pkg::ST_SETUP: begin
        mem_nxt.ce_n = 1'b0;
        cnt_nxt = '0;
        cyc_nxt = '0;
        state_nxt = nvmem_host_pkg::ST_ACTIVE;
      end
      nvmem_host_pkg::ST_ACTIVE: begin
        // RULE2: strobe-controlled write drops strobe after select
        if (req_r.write && !req_r.select_ctl && cnt_r == '0) begin
          mem_nxt.we_n = 1'b0;
        end
        // RULE5: select low for its least time
        if (cnt_r >= act_len - 1'b1) begin
          if (req_r.write && !req_r.select_ctl) begin
            // RULE10: select already low its least time
            // RULE8: strobe rises, select stays low one more cycle
            mem_nxt.we_n = 1'b1;
          end else begin
            mem_nxt.ce_n = 1'b1;
            mem_nxt.oe_n = 1'b1;
          end
          if (!req_r.write) begin
            // RULE4: byte sampled after access time plus sync
            rdata_nxt = dq_s2_r;
            rvalid_nxt = 1'b1;
          end
          state_nxt = req_r.write ? nvmem_host_pkg::ST_END : nvmem_host_pkg::ST_PRECHARGE;
          cnt_nxt = '0;
        end
      end
      // release the second strobe; write data held to here
      nvmem_host_pkg::ST_END: begin
        mem_nxt.ce_n = 1'b1;
        mem_nxt.we_n = 1'b1;
        cnt_nxt = '0;
        state_nxt = nvmem_host_pkg::ST_PRECHARGE;
      end
      nvmem_host_pkg::ST_PRECHARGE: begin
        // RULE9: data removed only after both strobes are high
        mem_nxt.dq_oe = 1'b0;
        if (cnt_r == '0 && req_r.write) begin
          // RULE13: write complete once strobe is high
          done_nxt = 1'b1;
        end
        // RULE14: precharge and full cycle both met
        if (cnt_r >= pc_min - 1'b1 && cyc_r >= cyc_min - 1'b1) begin
          state_nxt = nvmem_host_pkg::ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = nvmem_host_pkg::ST_IDLE;
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_r <= nvmem_host_pkg::ST_POWERUP;
      req_r <= '0;
      mem_r <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
      cnt_r <= '0;
      cyc_r <= '0;
      ready_r <= 1'b0;
      rvalid_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
      cyc_r <= cyc_nxt;
      ready_r <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign mem_o = mem_r;
  assign ready_o = ready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign done_o = done_r;

  // ****************************************
  // checks
  // ****************************************
  logic [nvmem_host_pkg::CNT_W-1:0] ce_lo_q, ce_hi_q, we_lo_q, dq_on_q;  // helper run lengths
  logic wr_both_low;  // both strobes low: a write is under way
  assign wr_both_low = !mem_r.we_n && !mem_r.ce_n;
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ce_lo_q <= '0;
      ce_hi_q <= '0;
      we_lo_q <= '0;
      dq_on_q <= '0;
    end else begin
      ce_lo_q <= mem_r.ce_n ? '0 : ce_lo_q + 1'b1;
      ce_hi_q <= !mem_r.ce_n ? '0 : (&ce_hi_q ? ce_hi_q : ce_hi_q + 1'b1);
      we_lo_q <= mem_r.we_n ? '0 : we_lo_q + 1'b1;
      dq_on_q <= mem_r.dq_oe ? dq_on_q + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  // a reset cuts an access short on purpose; the edge right after it is not judged
  select_low_a: assert property ($rose(mem_r.ce_n) && $past(resetn_i) |-> // RULE5
    $past(ce_lo_q) + 1'b1 >= sel_low)
    else $error("select released too early");
  strobe_width_a: assert property ($rose(mem_r.we_n) && !mem_r.ce_n |-> // RULE8
    $past(we_lo_q) + 1'b1 >= pick(req_r.low_supply, nvmem_host_pkg::STROBE_LO_CYC,
                                  nvmem_host_pkg::STROBE_HI_CYC))
    else $error("write strobe too short");
  // write ends when the first strobe rises; data driven long enough and still driven
  data_setup_a: assert property (wr_both_low ##1 !wr_both_low |-> // RULE9
    mem_r.dq_oe && $stable(mem_r.dq) && $past(dq_on_q) + 1'b1 >= pick(req_r.low_supply,
    nvmem_host_pkg::SETUP_LO_CYC, nvmem_host_pkg::SETUP_HI_CYC))
    else $error("write data not held");
  write_data_a: assert property (wr_both_low |-> mem_r.dq_oe && $stable(mem_r.dq)) // RULE9
    else $error("write data moved during write");
  select_before_rise_a: assert property ($rose(mem_r.we_n) && !mem_r.ce_n |-> // RULE10
    $past(ce_lo_q) + 1'b1 >= sel_low)
    else $error("select low too short before strobe rise");
  powerup_wait_a: assert property (!pwr_ok_r |-> mem_r.ce_n && mem_r.we_n) // RULE12
    else $error("access during power-up wait");
  precharge_a: assert property ($fell(mem_r.ce_n) |-> $past(ce_hi_q) + 1'b1 >= pc_min) // RULE14
    else $error("precharge too short");
  addr_hold_a: assert property (!mem_r.ce_n && !$past(mem_r.ce_n) |-> $stable(mem_r.addr)) // RULE15
    else $error("address moved while selected");
  write_style_a: assert property ($fell(mem_r.ce_n) && req_r.write |-> // RULE2
    mem_r.we_n == !req_r.select_ctl)
    else $error("write style order wrong");
  done_after_a: assert property ($rose(mem_r.we_n) |-> ##[1:3] done_r) // RULE13
    else $error("write completion not flagged");

  read_c: cover property (rvalid_r);
  sel_write_c: cover property (done_r && req_r.select_ctl);
  strobe_write_c: cover property (done_r && !req_r.select_ctl);
  back_to_back_c: cover property (ready_r && req_valid_i ##[1:60] ready_r && req_valid_i);

endmodule

//--- sim/nvmem_model.sv
`timescale 1ns/10ps
module nvmem_model (
  input wire logic low_i, // lower supply range timing
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [nvmem_host_pkg::ADDR_W-1:0] addr_i,
  input wire logic [nvmem_host_pkg::DATA_W-1:0] dq_line_i, // resolved byte lines
  output logic [nvmem_host_pkg::DATA_W-1:0] dq_o,
  output logic dq_en_o,
  output int viol_o // host timing faults seen
);
  // ****************************************
  // storage and timing marks
  // ****************************************
  logic [7:0] mem [0:(1<<nvmem_host_pkg::ADDR_W)-1];
  logic [12:0] lat_addr = 13'h0000; // latched location
  logic wr_on = 1'h0; // write in progress
  realtime t_cf = -1e6, t_cr = -1e6, t_wf = -1e6, t_wr = -1e6, t_of = -1e6, t_dq = -1e6;
  int acc_ns, oe_ns, sel_ns, pc_ns, cyc_ns, wp_ns, ds_ns;
  initial viol_o = 0;
  initial dq_o = 8'h00;
  // figures follow the supply range of the request
  always_comb begin
    acc_ns = low_i ? 80 : 70;
    oe_ns = low_i ? 15 : 12;
    sel_ns = low_i ? 80 : 70;
    pc_ns = low_i ? 65 : 60;
    cyc_ns = low_i ? 145 : 130;
    wp_ns = low_i ? 50 : 40;
    ds_ns = low_i ? 40 : 30;
  end
  task automatic commit;
    if ($realtime - t_dq < ds_ns) viol_o++;
    mem[lat_addr] = dq_line_i;
    wr_on = 1'h0;
  endtask
  // any wiggle restarts the setup window; a floating line wiggles every ns
  always @(dq_line_i) t_dq = $realtime;
  always @(negedge ce_n_i) begin
    if ($realtime - t_cr < pc_ns || $realtime - t_cf < cyc_ns) viol_o++;
    t_cf = $realtime;
    wr_on = !we_n_i;
    // address and select change in one time step; let the address settle first
    #0.5 lat_addr = addr_i;
  end
  always @(posedge ce_n_i) begin
    if ($realtime - t_cf < sel_ns) viol_o++;
    t_cr = $realtime;
    if (wr_on) commit();
  end
  always @(negedge we_n_i) begin
    t_wf = $realtime;
    if (!ce_n_i) wr_on = 1'h1;
  end
  always @(posedge we_n_i) begin
    t_wr = $realtime;
    if (wr_on && ($realtime - t_wf < wp_ns || $realtime - t_cf < sel_ns)) viol_o++;
    if (wr_on) commit();
  end
  always @(negedge oe_n_i) t_of = $realtime;
  always @(addr_i) begin
    if (!ce_n_i && $realtime > t_cf && $realtime - t_cf < 15) viol_o++;
  end
  // gated drive, delays, float
  // released lines toggle so a late sample never reads stale data
  always #1 begin
    dq_en_o = !ce_n_i && !oe_n_i && we_n_i && ($realtime - t_cf >= acc_ns)
      && ($realtime - t_of >= oe_ns) && ($realtime - t_wr >= 10);
    dq_o = dq_en_o ? mem[lat_addr] : ~dq_o;
  end
endmodule

//--- sim/nvmem_host_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module nvmem_host_tb;
  // ****************************************
  // signals
  // ****************************************
  localparam int PU = 40; // short power-up wait, still longer than a whole cycle
  logic sys_clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic req_valid_i = 1'h0;
  nvmem_host_pkg::req_s req_i = '0;
  nvmem_host_pkg::mem_pins_s mem_o;
  logic [7:0] dq_line, model_dq, rdata_o;
  logic model_en, ready_o, rvalid_o, done_o;
  int viol, v0, n;
  int mismatches = 0;
  int comparisons = 0;
  logic [31:0] rows [8]; // write, select_ctl, low_supply, addr, wdata, expected
  always #2 sys_clk_i = ~sys_clk_i;
  // both drivers at once shows as unknown
  assign dq_line = (mem_o.dq_oe && model_en) ? 8'hXX : (mem_o.dq_oe ? mem_o.dq : model_dq);
  nvmem_host #(.POWERUP_CYC(PU)) uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .mem_o(mem_o), .mem_dq_i(dq_line),
    .ready_o(ready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .done_o(done_o));
  nvmem_model mem_model (.low_i(req_i.low_supply), .ce_n_i(mem_o.ce_n), .we_n_i(mem_o.we_n),
    .oe_n_i(mem_o.oe_n), .addr_i(mem_o.addr), .dq_line_i(dq_line), .dq_o(model_dq),
    .dq_en_o(model_en), .viol_o(viol));
  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one access; entered and left at a falling edge
  task automatic run(input logic [31:0] r);
    req_i = r[31:8];
    req_valid_i = 1'h1;
    n = 0;
    while (ready_o !== 1'h1 && n < 200) begin @(negedge sys_clk_i); n++; end
    @(negedge sys_clk_i);
    req_valid_i = 1'h0;
    n = 0;
    while (rvalid_o !== 1'h1 && done_o !== 1'h1 && n < 100) begin
      @(negedge sys_clk_i);
      n++;
    end
    `CHK(req_i.write ? done_o : rvalid_o, 1'h1)
    `CHK(req_i.write ? {mem_o.ce_n, mem_o.we_n} : 2'h3, 2'h3)
    `CHK(req_i.write ? 8'h00 : rdata_o, r[7:0])
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows[0] = {1'h1, 1'h1, 1'h1, 13'h0000, 8'hA5, 8'h00};
    rows[1] = {1'h1, 1'h0, 1'h0, 13'h1FFF, 8'h5A, 8'h00};
    rows[2] = {1'h0, 1'h0, 1'h1, 13'h0000, 8'h00, 8'hA5};
    rows[3] = {1'h0, 1'h0, 1'h0, 13'h1FFF, 8'h00, 8'h5A};
    rows[4] = {1'h1, 1'h0, 1'h1, 13'h0001, 8'h3C, 8'h00};
    rows[5] = {1'h1, 1'h1, 1'h0, 13'h0001, 8'hC3, 8'h00};
    rows[6] = {1'h0, 1'h0, 1'h0, 13'h0001, 8'h00, 8'hC3};
    rows[7] = {1'h0, 1'h0, 1'h1, 13'h1FFF, 8'h00, 8'h5A};
    repeat (2) @(negedge sys_clk_i);
    `CHK({mem_o.ce_n, mem_o.we_n, mem_o.oe_n, mem_o.dq_oe, ready_o}, 5'h1C)
    resetn_i = 1'h1;
    n = 0;
    while (ready_o !== 1'h1 && n < 1000) begin @(negedge sys_clk_i); n++; end
    `CHK(n >= PU, 1'h1)
    `CHK(ready_o, 1'h1)
    $display("power-up test done");
    // table rows: both write styles, both supply ranges, back to back
    foreach (rows[i]) begin
      run(rows[i]);
      $display("row %0d done", i);
    end
    `CHK(viol, 0)
    // reset in mid-read: one short select is the only fault allowed
    v0 = viol;
    req_i = rows[3][31:8];
    req_valid_i = 1'h1;
    n = 0;
    // the read must really start before the reset cuts it
    while (ready_o !== 1'h1 && n < 200) begin @(negedge sys_clk_i); n++; end
    @(negedge sys_clk_i);
    req_valid_i = 1'h0;
    repeat (8) @(negedge sys_clk_i);
    resetn_i = 1'h0;
    @(negedge sys_clk_i);
    `CHK({mem_o.ce_n, mem_o.we_n, mem_o.oe_n, mem_o.dq_oe}, 4'hE)
    resetn_i = 1'h1;
    `CHK(viol, v0 + 1)
    run(rows[2]);
    $display("abort test done");
    `CHK(viol, v0 + 1)
    test_done;
  end
  // watchdog, well beyond the few thousand ns the sequence needs
  initial begin
    #40000;
    mismatches++;
    test_done;
  end
endmodule
